// >>> core/barsxs_alu.sv
`timescale 1ns/10ps
`default_nettype none
module barsxs_alu
  import barsxs_pkg::*;
(
  barsxs_alu_if.alu alu_bus
);

  wire logic              is_rot  = (alu_bus.op == OP_ROTATE_RIGHT_THRU_CARRY);
  wire logic              is_lsub = (alu_bus.op == OP_LITERAL_MINUS_ACCUM);
  wire logic              is_rsub = (alu_bus.op == OP_REG_MINUS_ACCUM);
  wire logic              is_xl   = (alu_bus.op == OP_XOR_LITERAL_ACCUM);
  wire logic              is_xr   = (alu_bus.op == OP_XOR_REG_ACCUM);
  wire logic              is_sub  = is_lsub | is_rsub;
  wire logic              is_xor  = is_xl | is_xr;

  // Subtraction as minuend + ~accum + 1, so carry out means no borrow
  wire logic [DATA_W-1:0] minuend   = is_lsub ? alu_bus.literal : alu_bus.operand;
  wire logic [DATA_W:0]   diff_full = {1'b0, minuend} + {1'b0, ~alu_bus.accum} + 9'h001;
  wire logic [4:0]        diff_low  = {1'b0, minuend[3:0]} + {1'b0, ~alu_bus.accum[3:0]} + 5'h01;
  wire logic [DATA_W-1:0] xor_src   = is_xl ? alu_bus.literal : alu_bus.operand;

  assign alu_bus.result    = is_rot ? {alu_bus.carry_in, alu_bus.operand[7:1]} :
                             is_sub ? diff_full[DATA_W-1:0] :
                             is_xor ? (alu_bus.accum ^ xor_src) :
                                      {alu_bus.operand[3:0], alu_bus.operand[7:4]};
  assign alu_bus.carry_out = is_rot ? alu_bus.operand[0] : diff_full[DATA_W];
  assign alu_bus.nc_out    = diff_low[4];
  assign alu_bus.zero_out  = (alu_bus.result == 8'h00);
  assign alu_bus.wr_carry  = is_rot | is_sub;
  assign alu_bus.wr_nc     = is_sub;
  assign alu_bus.wr_zero   = is_sub | is_xor;
  assign alu_bus.reg_form  = ~(is_lsub | is_xl);

endmodule
`default_nettype wire

// >>> core/barsxs_alu_if.sv
`timescale 1ns/10ps
`default_nettype none
interface barsxs_alu_if;
  import barsxs_pkg::*;
  barsxs_op_t        op;
  logic [DATA_W-1:0] operand;
  logic [DATA_W-1:0] accum;
  logic [DATA_W-1:0] literal;
  logic              carry_in;
  logic [DATA_W-1:0] result;
  logic              carry_out;
  logic              nc_out;
  logic              zero_out;
  logic              wr_carry;
  logic              wr_nc;
  logic              wr_zero;
  logic              reg_form;

  modport core (output op, operand, accum, literal, carry_in,
                input  result, carry_out, nc_out, zero_out, wr_carry, wr_nc, wr_zero,
                       reg_form);
  modport alu  (input  op, operand, accum, literal, carry_in,
                output result, carry_out, nc_out, zero_out, wr_carry, wr_nc, wr_zero,
                       reg_form);
endinterface
`default_nettype wire

// >>> core/barsxs_avs.sv
`timescale 1ns/10ps
`default_nettype none
module barsxs_avs
  import barsxs_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  input  wire logic req_i,
  output logic      waitrequest_o,
  output logic      capture_o,
  output logic      accept_o
);

  barsxs_bus_t state_reg;
  barsxs_bus_t state_next;
  logic        wait_reg;

  // One cycle to sample read data, answer in the next
  always_comb begin
    case (state_reg)
      BUS_IDLE:   state_next = req_i ? BUS_ANSWER : BUS_IDLE;
      BUS_ANSWER: state_next = BUS_IDLE;
      default:    state_next = BUS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_reg <= BUS_IDLE;
      wait_reg  <= 1'b1;
    end else begin
      state_reg <= state_next;
      wait_reg  <= (state_next != BUS_ANSWER);
    end
  end

  assign waitrequest_o = wait_reg;
  assign capture_o     = (state_reg == BUS_IDLE) && req_i;
  assign accept_o      = (state_reg == BUS_ANSWER) && req_i;

endmodule
`default_nettype wire

// >>> core/barsxs_pkg.sv
package barsxs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and sizes
  localparam int unsigned DATA_W         = 8;
  localparam int unsigned REG_IDX_W      = 7;
  localparam int unsigned REG_FILE_DEPTH = 128;
  localparam int unsigned AVS_ADDR_W     = 10;
  localparam int unsigned AVS_DATA_W     = 32;
  localparam int unsigned AVS_BE_W       = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses)
  localparam logic [AVS_ADDR_W-1:0] OFS_CMD    = 10'h000;
  localparam logic [AVS_ADDR_W-1:0] OFS_ACCUM  = 10'h004;
  localparam logic [AVS_ADDR_W-1:0] OFS_STATUS = 10'h008;
  localparam logic [AVS_ADDR_W-1:0] OFS_RESULT = 10'h00C;
  // Data register window: 0x200 + 4 * index
  localparam int unsigned REGS_SEL_BIT = 9;
  localparam int unsigned REGS_IDX_LSB = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Command word fields
  localparam int unsigned CMD_OP_LSB  = 0;
  localparam int unsigned CMD_OP_W    = 3;
  localparam int unsigned CMD_TGT_BIT = 3;
  localparam int unsigned CMD_IDX_LSB = 4;
  localparam int unsigned CMD_LIT_LSB = 16;
  localparam int unsigned CMD_W       = 24;

  // Status word fields
  localparam int unsigned STAT_C_BIT   = 0;
  localparam int unsigned STAT_NC_BIT  = 1;
  localparam int unsigned STAT_Z_BIT   = 2;
  localparam int unsigned STAT_ILL_BIT = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [DATA_W-1:0] ACCUM_RST  = 8'h00;
  localparam logic [DATA_W-1:0] RESULT_RST = 8'h00;
  localparam logic [CMD_W-1:0]  CMD_RST    = 24'h000000;
  localparam logic              FLAG_RST   = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [CMD_OP_W-1:0] {
    OP_ROTATE_RIGHT_THRU_CARRY,
    OP_LITERAL_MINUS_ACCUM,
    OP_REG_MINUS_ACCUM,
    OP_XOR_LITERAL_ACCUM,
    OP_XOR_REG_ACCUM,
    OP_NIBBLE_EXCHANGE
  } barsxs_op_t;

  typedef enum logic {
    BUS_IDLE,
    BUS_ANSWER
  } barsxs_bus_t;

endpackage

// >>> core/barsxs_top.sv
`timescale 1ns/10ps
`default_nettype none
module barsxs_top
  import barsxs_pkg::*;
#(
  parameter int unsigned REG_DEPTH = REG_FILE_DEPTH
) (
  input  wire logic                  core_clk_i,
  input  wire logic                  srst_i,
  input  wire logic [AVS_ADDR_W-1:0] avs_address_i,
  input  wire logic                  avs_read_i,
  input  wire logic                  avs_write_i,
  input  wire logic [AVS_DATA_W-1:0] avs_writedata_i,
  input  wire logic [AVS_BE_W-1:0]   avs_byteenable_i,
  output logic      [AVS_DATA_W-1:0] avs_readdata_o,
  output logic                       avs_waitrequest_o,
  output logic      [DATA_W-1:0]     accum_o,
  output logic                       carry_o,
  output logic                       nibble_carry_flag_o,
  output logic                       zero_o,
  output logic                       exec_done_o
);

  if ((REG_DEPTH == 0) || (REG_DEPTH > REG_FILE_DEPTH)) begin : g_depth_check
    $error("REG_DEPTH must be between 1 and the register index range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [DATA_W-1:0]     accum_reg;
  logic [DATA_W-1:0]     accum_next;
  logic                  carry_reg;
  logic                  carry_next;
  logic                  nc_reg;
  logic                  nc_next;
  logic                  zero_reg;
  logic                  zero_next;
  logic                  illegal_reg;
  logic                  illegal_next;
  logic [DATA_W-1:0]     result_reg;
  logic [DATA_W-1:0]     result_next;
  logic [CMD_W-1:0]      cmd_reg;
  logic [CMD_W-1:0]      cmd_next;
  logic [AVS_DATA_W-1:0] readdata_reg;
  logic [AVS_DATA_W-1:0] readdata_next;
  logic                  exec_done_reg;
  logic [DATA_W-1:0]     regfile [REG_DEPTH];

  barsxs_alu_if alu_bus ();

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake

  logic bus_capture;
  logic bus_accept;

  barsxs_avs u_avs (
    .core_clk_i    (core_clk_i),
    .srst_i        (srst_i),
    .req_i         (avs_read_i | avs_write_i),
    .waitrequest_o (avs_waitrequest_o),
    .capture_o     (bus_capture),
    .accept_o      (bus_accept)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  wire logic                 hit_cmd    = (avs_address_i == OFS_CMD);
  wire logic                 hit_accum  = (avs_address_i == OFS_ACCUM);
  wire logic                 hit_status = (avs_address_i == OFS_STATUS);
  wire logic                 hit_result = (avs_address_i == OFS_RESULT);
  wire logic                 hit_regs   = avs_address_i[REGS_SEL_BIT];
  wire logic [REG_IDX_W-1:0] bus_idx    = avs_address_i[REGS_IDX_LSB +: REG_IDX_W];
  wire logic                 bus_idx_ok = (32'(bus_idx) < REG_DEPTH);
  wire logic                 bus_wr     = bus_accept & avs_write_i;
  wire logic                 wr_lane0   = bus_wr & avs_byteenable_i[0];
  wire logic                 accum_wr   = wr_lane0 & hit_accum;
  wire logic                 status_wr  = wr_lane0 & hit_status;
  wire logic                 regs_wr    = wr_lane0 & hit_regs & bus_idx_ok;
  wire logic                 cmd_wr     = bus_wr & hit_cmd;

  ////////////////////////////////////////////////////////////////////////////
  // Command word: merged by lane, executes when its low byte is written

  wire logic [CMD_W-1:0] cmd_merged = {
    avs_byteenable_i[2] ? avs_writedata_i[23:16] : cmd_reg[23:16],
    avs_byteenable_i[1] ? avs_writedata_i[15:8]  : cmd_reg[15:8],
    avs_byteenable_i[0] ? avs_writedata_i[7:0]   : cmd_reg[7:0]
  };

  wire logic [CMD_OP_W-1:0]  op_code      = cmd_merged[CMD_OP_LSB +: CMD_OP_W];
  wire logic                 exec_target  = cmd_merged[CMD_TGT_BIT];
  wire logic [REG_IDX_W-1:0] exec_idx     = cmd_merged[CMD_IDX_LSB +: REG_IDX_W];
  wire logic [DATA_W-1:0]    exec_literal = cmd_merged[CMD_LIT_LSB +: DATA_W];
  wire logic                 idx_ok       = (32'(exec_idx) < REG_DEPTH);
  wire logic                 op_valid     = (op_code <= OP_NIBBLE_EXCHANGE);
  wire logic                 exec_go      = cmd_wr & avs_byteenable_i[0];
  wire logic                 exec_ok      = exec_go & op_valid;

  // Registers past REG_DEPTH read as zero and drop writes
  wire logic [DATA_W-1:0]    exec_operand = idx_ok ? regfile[exec_idx] : 8'h00;

  assign alu_bus.op       = barsxs_op_t'(op_code);
  assign alu_bus.operand  = exec_operand;
  assign alu_bus.accum    = accum_reg;
  assign alu_bus.literal  = exec_literal;
  assign alu_bus.carry_in = carry_reg;

  barsxs_alu u_alu (
    .alu_bus (alu_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  wire logic to_reg   = alu_bus.reg_form & exec_target;
  wire logic to_accum = exec_ok & ~to_reg;

  assign accum_next   = to_accum  ? alu_bus.result :
                        accum_wr  ? avs_writedata_i[7:0] : accum_reg;
  assign carry_next   = (exec_ok & alu_bus.wr_carry) ? alu_bus.carry_out :
                        status_wr ? avs_writedata_i[STAT_C_BIT] : carry_reg;
  assign nc_next      = (exec_ok & alu_bus.wr_nc) ? alu_bus.nc_out :
                        status_wr ? avs_writedata_i[STAT_NC_BIT] : nc_reg;
  assign zero_next    = (exec_ok & alu_bus.wr_zero) ? alu_bus.zero_out :
                        status_wr ? avs_writedata_i[STAT_Z_BIT] : zero_reg;
  assign illegal_next = exec_go ? ~op_valid : illegal_reg;
  assign result_next  = exec_ok ? alu_bus.result : result_reg;
  assign cmd_next     = cmd_wr ? cmd_merged : cmd_reg;

  wire logic [AVS_DATA_W-1:0] status_word =
    (32'(carry_reg)   << STAT_C_BIT)  | (32'(nc_reg)      << STAT_NC_BIT) |
    (32'(zero_reg)    << STAT_Z_BIT)  | (32'(illegal_reg) << STAT_ILL_BIT);

  wire logic [AVS_DATA_W-1:0] rd_word =
    hit_cmd                 ? 32'(cmd_reg)    :
    hit_accum               ? 32'(accum_reg)  :
    hit_status              ? status_word     :
    hit_result              ? 32'(result_reg) :
    (hit_regs & bus_idx_ok) ? 32'(regfile[bus_idx]) : 32'h00000000;

  // Sampled one cycle early; nothing can change it before the answer edge
  assign readdata_next = (bus_capture & avs_read_i) ? rd_word : readdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      accum_reg     <= ACCUM_RST;
      carry_reg     <= FLAG_RST;
      nc_reg        <= FLAG_RST;
      zero_reg      <= FLAG_RST;
      illegal_reg   <= FLAG_RST;
      result_reg    <= RESULT_RST;
      cmd_reg       <= CMD_RST;
      readdata_reg  <= 32'h00000000;
      exec_done_reg <= 1'b0;
    end else begin
      accum_reg     <= accum_next;
      carry_reg     <= carry_next;
      nc_reg        <= nc_next;
      zero_reg      <= zero_next;
      illegal_reg   <= illegal_next;
      result_reg    <= result_next;
      cmd_reg       <= cmd_next;
      readdata_reg  <= readdata_next;
      exec_done_reg <= exec_ok;
    end
  end

  // Plain memory, no reset: software must load it before use
  always_ff @(posedge core_clk_i) begin
    if (exec_ok && to_reg && idx_ok) begin
      regfile[exec_idx] <= alu_bus.result;
    end else if (regs_wr) begin
      regfile[bus_idx] <= avs_writedata_i[7:0];
    end
  end

  assign avs_readdata_o      = readdata_reg;
  assign accum_o             = accum_reg;
  assign carry_o             = carry_reg;
  assign nibble_carry_flag_o = nc_reg;
  assign zero_o              = zero_reg;
  assign exec_done_o         = exec_done_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  wire logic run_rot  = exec_ok && (alu_bus.op == OP_ROTATE_RIGHT_THRU_CARRY);
  wire logic run_lsub = exec_ok && (alu_bus.op == OP_LITERAL_MINUS_ACCUM);
  wire logic run_rsub = exec_ok && (alu_bus.op == OP_REG_MINUS_ACCUM);
  wire logic run_xl   = exec_ok && (alu_bus.op == OP_XOR_LITERAL_ACCUM);
  wire logic run_xr   = exec_ok && (alu_bus.op == OP_XOR_REG_ACCUM);
  wire logic run_swap = exec_ok && (alu_bus.op == OP_NIBBLE_EXCHANGE);

  wire logic [DATA_W-1:0] chk_lit_diff = exec_literal - accum_reg;
  wire logic [DATA_W-1:0] chk_reg_diff = exec_operand - accum_reg;

  a_rotate_value:
    assert property (run_rot |=> result_reg == {$past(carry_reg), $past(exec_operand[7:1])}
                     && carry_reg == $past(exec_operand[0]))
    else $error("rotate result or carry wrong");

  a_rotate_flags:
    assert property (run_rot |=> $stable(nc_reg) && $stable(zero_reg))
    else $error("rotate touched a flag other than carry");

  a_target_accum:
    assert property (exec_ok && alu_bus.reg_form && !exec_target
                     |=> accum_reg == result_reg)
    else $error("result did not reach accumulator");

  a_target_reg:
    assert property (exec_ok && alu_bus.reg_form && exec_target && idx_ok
                     |=> regfile[$past(exec_idx)] == result_reg && $stable(accum_reg))
    else $error("result did not reach the register");

  a_lit_sub_value:
    assert property (run_lsub |=> accum_reg == $past(chk_lit_diff)
                     && carry_reg == ($past(accum_reg) <= $past(exec_literal)))
    else $error("literal subtract value or carry wrong");

  a_lit_sub_nibble:
    assert property (run_lsub |=> nc_reg == ($past(accum_reg[3:0]) <= $past(exec_literal[3:0])))
    else $error("literal subtract nibble carry wrong");

  a_reg_sub_value:
    assert property (run_rsub |=> result_reg == $past(chk_reg_diff))
    else $error("register subtract value wrong");

  a_reg_sub_carry:
    assert property (run_rsub |=> carry_reg == ($past(accum_reg) <= $past(exec_operand)))
    else $error("register subtract carry wrong");

  a_reg_sub_nibble:
    assert property (run_rsub |=> nc_reg == ($past(accum_reg[3:0]) <= $past(exec_operand[3:0])))
    else $error("register subtract nibble carry wrong");

  a_xor_literal:
    assert property (run_xl |=> accum_reg == ($past(accum_reg) ^ $past(exec_literal))
                     && $stable(carry_reg) && $stable(nc_reg))
    else $error("literal xor wrong or flags disturbed");

  a_xor_register:
    assert property (run_xr |=> result_reg == ($past(accum_reg) ^ $past(exec_operand))
                     && $stable(carry_reg) && $stable(nc_reg))
    else $error("register xor wrong or flags disturbed");

  a_swap_halves:
    assert property (run_swap |=> result_reg == {$past(exec_operand[3:0]), $past(exec_operand[7:4])}
                     && $stable(carry_reg) && $stable(nc_reg) && $stable(zero_reg))
    else $error("nibble exchange wrong or flags disturbed");

  a_zero_result:
    assert property (exec_ok && alu_bus.wr_zero |=> zero_reg == (result_reg == 8'h00))
    else $error("zero flag disagrees with result");

  a_bus_answer:
    assert property (bus_capture |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer not exactly one cycle after capture");

  a_rot_to_reg:
    assert property (run_rot && exec_target && idx_ok
                     |=> regfile[$past(exec_idx)]
                         == {$past(carry_reg), $past(exec_operand[7:1])})
    else $error("rotate result did not reach the register");

  a_rsub_to_reg:
    assert property (run_rsub && exec_target && idx_ok
                     |=> regfile[$past(exec_idx)] == $past(chk_reg_diff))
    else $error("register subtract result did not reach the register");

  a_reg_kept:
    assert property (exec_ok && alu_bus.reg_form && !exec_target && idx_ok
                     |=> regfile[$past(exec_idx)] == $past(exec_operand))
    else $error("register changed although the accumulator was the target");

  a_literal_target:
    assert property (exec_ok && !alu_bus.reg_form |=> accum_reg == result_reg)
    else $error("literal form result did not reach accumulator");

  a_zero_kept:
    assert property (exec_ok && !alu_bus.wr_zero |=> $stable(zero_reg))
    else $error("zero flag changed by rotate or exchange");

  a_illegal_op:
    assert property (exec_go && !op_valid
                     |=> illegal_reg && $stable(accum_reg)
                         && $stable(result_reg) && $stable(carry_reg))
    else $error("undefined opcode not refused");

  a_done_pulse:
    assert property (exec_ok |=> exec_done_o ##1 !exec_done_o)
    else $error("execution pulse not exactly one cycle");

  a_done_quiet:
    assert property (!exec_ok |=> !exec_done_o)
    else $error("execution pulse without a command");

  ////////////////////////////////////////////////////////////////////////////
  // Register access checks

  a_wait_idle:
    assert property (!$past(bus_capture) |-> avs_waitrequest_o)
    else $error("waitrequest low without a captured request");

  a_accept_answer:
    assert property (bus_accept |-> !avs_waitrequest_o)
    else $error("request accepted while waitrequest high");

  a_readdata_hold:
    assert property (!(bus_capture && avs_read_i) |=> $stable(avs_readdata_o))
    else $error("read data changed without a read");

  a_accum_write:
    assert property (accum_wr |=> accum_reg == $past(avs_writedata_i[7:0]))
    else $error("accumulator write lost");

  a_status_write:
    assert property (status_wr |=> carry_reg == $past(avs_writedata_i[STAT_C_BIT])
                     && nc_reg == $past(avs_writedata_i[STAT_NC_BIT])
                     && zero_reg == $past(avs_writedata_i[STAT_Z_BIT]))
    else $error("status write lost");

  c_rotate_to_reg:   cover property (run_rot && exec_target);
  c_lit_sub_borrow:  cover property (run_lsub && (accum_reg > exec_literal));
  c_reg_sub_to_acc:  cover property (run_rsub && !exec_target);
  c_swap_to_reg:     cover property (run_swap && exec_target);
  c_illegal_opcode:  cover property (exec_go && !op_valid);

endmodule
`default_nettype wire

// >>> tb/byte_alu_rotate_sub_xor_swap_test.sv
`timescale 1ns/10ps
`default_nettype none
module byte_alu_rotate_sub_xor_swap_test;
  import barsxs_pkg::*;
  logic                  core_clk_i = 1'b0;
  logic                  srst_i     = 1'b1;
  logic [AVS_ADDR_W-1:0] address    = 10'h000;
  logic                  rd         = 1'b0;
  logic                  wr         = 1'b0;
  logic [AVS_DATA_W-1:0] wdata      = 32'h00000000;
  logic [AVS_DATA_W-1:0] rdata;
  logic                  waitreq;
  logic [DATA_W-1:0]     accum;
  logic                  carry;
  logic                  ncarry;
  logic                  zero;
  logic                  done;
  int                    failures   = 0;
  int                    checks     = 0;

  barsxs_top dut (
    .core_clk_i          (core_clk_i),
    .srst_i              (srst_i),
    .avs_address_i       (address),
    .avs_read_i          (rd),
    .avs_write_i         (wr),
    .avs_writedata_i     (wdata),
    .avs_byteenable_i    (4'hF),
    .avs_readdata_o      (rdata),
    .avs_waitrequest_o   (waitreq),
    .accum_o             (accum),
    .carry_o             (carry),
    .nibble_carry_flag_o (ncarry),
    .zero_o              (zero),
    .exec_done_o         (done)
  );

  always #2.5 core_clk_i = ~core_clk_i;

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // Request held until waitrequest is sampled low; only the watchdog ends a hang
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge core_clk_i);
    address <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    do begin
      @(posedge core_clk_i);
    end while (waitreq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic put(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  // Flags packed as {zero, nibble carry, carry}
  task automatic exec(input logic [2:0] op, input logic tgt, input logic [6:0] idx,
                      input logic [7:0] lit, input logic [7:0] a0, input logic [7:0] r0,
                      input logic [2:0] f0);
    logic [7:0]  res;
    logic [7:0]  racc;
    logic [7:0]  rreg;
    logic [2:0]  f;
    logic        reg_dst;
    logic [31:0] q;
    put({1'b1, idx, 2'h0}, {24'h000000, r0});
    put(OFS_ACCUM, {24'h000000, a0});
    put(OFS_STATUS, {29'h00000000, f0});
    f = f0;
    case (op)
      3'h0: begin
        res = {f0[0], r0[7:1]};
        f[0] = r0[0];
      end
      3'h1: begin
        res = lit - a0;
        f[1:0] = {a0[3:0] <= lit[3:0], a0 <= lit};
      end
      3'h2: begin
        res = r0 - a0;
        f[1:0] = {a0[3:0] <= r0[3:0], a0 <= r0};
      end
      3'h3: res = lit ^ a0;
      3'h4: res = r0 ^ a0;
      default: res = {r0[3:0], r0[7:4]};
    endcase
    if (op inside {3'h1, 3'h2, 3'h3, 3'h4}) begin
      f[2] = (res == 8'h00);
    end
    reg_dst = tgt && !(op inside {3'h1, 3'h3});
    racc = reg_dst ? a0 : res;
    rreg = reg_dst ? res : r0;
    put(OFS_CMD, {8'h00, lit, 5'h00, idx, tgt, op});
    #1;
    chk("exec_done", 32'h1, {31'h0, done});
    chk("accum", {24'h0, racc}, {24'h0, accum});
    chk("flags", {29'h0, f}, {29'h0, zero, ncarry, carry});
    bus(1'b0, {1'b1, idx, 2'h0}, 32'h0, q);
    chk("data_reg", {24'h0, rreg}, {24'h0, q[7:0]});
    chk("exec_done_low", 32'h0, {31'h0, done});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [31:0] q;
    #1;
    chk("waitreq_rst", 32'h1, {31'h0, waitreq});
    chk("accum_rst", {24'h0, ACCUM_RST}, {24'h0, accum});
    bus(1'b0, 10'h010, 32'h0, q);
    chk("unmapped", 32'h0, q);
  endtask

  task automatic t_rotate;
    exec(3'h0, 1'b0, 7'h05, 8'h00, 8'h11, 8'h93, 3'h7);
    exec(3'h0, 1'b1, 7'h7F, 8'h00, 8'h3C, 8'h01, 3'h0);
    exec(3'h0, 1'b1, 7'h20, 8'h00, 8'h00, 8'h6A, 3'h5);
  endtask

  task automatic t_lit_sub;
    exec(3'h1, 1'b0, 7'h01, 8'h05, 8'h05, 8'h77, 3'h0);
    exec(3'h1, 1'b0, 7'h01, 8'h05, 8'h06, 8'h77, 3'h7);
    exec(3'h1, 1'b1, 7'h02, 8'h20, 8'h1F, 8'h55, 3'h6);
    exec(3'h1, 1'b0, 7'h02, 8'h1F, 8'h20, 8'h55, 3'h1);
  endtask

  task automatic t_reg_sub;
    exec(3'h2, 1'b0, 7'h10, 8'h00, 8'h80, 8'h80, 3'h0);
    exec(3'h2, 1'b1, 7'h11, 8'h00, 8'h4D, 8'h3C, 3'h7);
    exec(3'h2, 1'b1, 7'h12, 8'h00, 8'h01, 8'h00, 3'h4);
    exec(3'h2, 1'b0, 7'h13, 8'h00, 8'h0F, 8'hF0, 3'h3);
  endtask

  task automatic t_xor;
    exec(3'h3, 1'b0, 7'h30, 8'hA5, 8'hA5, 8'h12, 3'h3);
    exec(3'h3, 1'b1, 7'h30, 8'h0F, 8'hF0, 8'h12, 3'h4);
    exec(3'h4, 1'b1, 7'h31, 8'h00, 8'h0F, 8'h5A, 3'h7);
    exec(3'h4, 1'b0, 7'h32, 8'h00, 8'hC3, 8'hC3, 3'h2);
  endtask

  task automatic t_swap;
    logic [31:0] q;
    exec(3'h5, 1'b0, 7'h40, 8'h00, 8'h99, 8'h1E, 3'h5);
    exec(3'h5, 1'b1, 7'h41, 8'h00, 8'h66, 8'hB4, 3'h2);
    put(OFS_CMD, 32'h00000006);
    bus(1'b0, OFS_STATUS, 32'h0, q);
    chk("illegal_flag", 32'h1, {31'h0, q[STAT_ILL_BIT]});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge core_clk_i);
    srst_i <= 1'b0;
    @(posedge core_clk_i);
    t_reset;
    t_rotate;
    t_lit_sub;
    t_reg_sub;
    t_xor;
    t_swap;
    end_sim;
  end

  // Whole run needs under 300 cycles
  initial begin
    #200000;
    failures++;
    end_sim;
  end
endmodule
`default_nettype wire
